//--- rtl/bafs_regs.sv
// Functional notes
// R01 - Set thermal alert bit 14 when any balancing halts on thermal fault.
// R02 - Thermal alert only raised while thermal enable setting is one.
// R03 - Thermal and calibration alerts cleared by writing zero; writing one ignored.
// R04 - Set calibration alert bit 13 when discharge or automated balancing halts.
// R05 - Set progress alert bit 12 periodically during discharge or automated balancing.
// R06 - Progress notice configuration field enables and paces progress alert.
// R07 - Set completion alert bit 11 on normal timed or undervoltage exit.
// R08 - Progress and completion alerts cleared only by written zero.
// R09 - Halt and completion alerts read zero while disabled or running; here the alert bits always read as stored, with no gating.
// R10 - Fault bits 13..10 read-only, 15,14,9..1 write-zero clear, bit 0 writable external.
// R11 - Sixteen-bit fault summary register, resets to zero.
//
// Chosen here: register access over AXI4-Lite.
module bafs_regs
    import bafs_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [bafs_pkg::ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [bafs_pkg::ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic i_thermal_halt,
    input wire logic i_calib_halt,
    input wire logic i_progress_tick,
    input wire logic i_balance_done,
    input wire logic [15:0] i_fault_set,
    input wire logic [15:0] i_fault_ro,
    input wire logic i_fault_ext0,
    output logic o_thermal_enable,
    output logic [bafs_pkg::NOTICE_W-1:0] o_progress_notice_config,
    output logic o_irq
);
    import bafs_pkg::*;

    typedef struct packed {
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [15:0] w_data;
        logic [1:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [15:0] alert;
        logic [15:0] fault;
        logic [15:0] irq_status;
        logic [15:0] irq_enable;
        logic thermal_enable;
        logic [NOTICE_W-1:0] notice_cfg;
        logic [1:0] tick_cnt;
        logic [15:0] alert_q;
        logic [15:0] fault_q;
    } bafs_state_s;

    bafs_state_s state_reg;
    bafs_state_s state_next;

    // Zero-clear: a written zero with its lane enabled clears, any one leaves the bit
    function automatic logic [15:0] zero_clear(input logic [15:0] cur, input logic [15:0] wd,
                                               input logic [1:0] strb, input logic [15:0] mask);
        logic [15:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}};
        zero_clear = cur & ~(mask & lanes & ~wd);
    endfunction : zero_clear

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a == OFF_ALERT_STATUS) || (a == OFF_FAULT_SUMMARY) || (a == OFF_IRQ_STATUS)
              || (a == OFF_IRQ_CLEAR) || (a == OFF_IRQ_ENABLE) || (a == OFF_CONFIG)
              || (a == OFF_ENGINE);
    endfunction : mapped

    logic do_write;
    logic do_read;
    logic [15:0] alert_set;
    logic [15:0] fault_new;
    logic [15:0] events;
    logic notice_fire;
    logic [15:0] wlanes;

    always_comb
    begin
        state_next = state_reg;
        do_write = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
        do_read = i_arvalid && !state_reg.rvalid;
        wlanes = {{8{state_reg.w_strb[1]}}, {8{state_reg.w_strb[0]}}};
        // Progress pacing: every tick, every second or every fourth
        case (state_reg.notice_cfg)
            NOTICE_OFF: notice_fire = 1'b0;
            NOTICE_EACH: notice_fire = i_progress_tick; // R06
            NOTICE_HALF: notice_fire = i_progress_tick && state_reg.tick_cnt[0]; // R06
            NOTICE_QUARTER: notice_fire = i_progress_tick && (state_reg.tick_cnt == 2'h3); // R06
            default: notice_fire = 1'b0;
        endcase
        if (i_progress_tick && state_reg.notice_cfg != NOTICE_OFF)
        begin
            state_next.tick_cnt = state_reg.tick_cnt + 2'h1;
        end
        else if (state_reg.notice_cfg == NOTICE_OFF)
        begin
            state_next.tick_cnt = 2'h0;
        end
        alert_set = ZERO16;
        alert_set[BIT_THERMAL] = i_thermal_halt && state_reg.thermal_enable; // R01 R02
        alert_set[BIT_CALIB] = i_calib_halt; // R04
        alert_set[BIT_PROGRESS] = notice_fire; // R05
        alert_set[BIT_COMPLETE] = i_balance_done; // R07

        // Write channel capture, either order
        if (i_awvalid && !state_reg.aw_held)
        begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = i_awaddr;
        end
        if (i_wvalid && !state_reg.w_held)
        begin
            state_next.w_held = 1'b1;
            state_next.w_data = i_wdata[15:0];
            state_next.w_strb = i_wstrb[1:0];
        end

        state_next.alert = state_reg.alert;
        state_next.fault = state_reg.fault;
        if (do_write)
        begin
            state_next.aw_held = 1'b0;
            state_next.w_held = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = mapped(state_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            case (state_reg.aw_addr)
                OFF_ALERT_STATUS: state_next.alert = zero_clear(state_reg.alert, state_reg.w_data,
                                                                state_reg.w_strb, ALERT_MASK); // R03 R08
                OFF_FAULT_SUMMARY:
                begin
                    state_next.fault = zero_clear(state_reg.fault, state_reg.w_data,
                                                  state_reg.w_strb, FAULT_W0C_MASK); // R10
                    if (state_reg.w_strb[0])
                    begin
                        state_next.fault[0] = state_reg.w_data[0]; // R10
                    end
                end
                OFF_IRQ_CLEAR: state_next.irq_status = state_reg.irq_status & ~(state_reg.w_data & wlanes);
                OFF_IRQ_ENABLE: state_next.irq_enable = (state_reg.irq_enable & ~wlanes)
                                                       | (state_reg.w_data & wlanes);
                OFF_CONFIG:
                begin
                    if (state_reg.w_strb[0])
                    begin
                        state_next.thermal_enable = state_reg.w_data[CFG_THERMAL_EN_BIT]; // R02
                        state_next.notice_cfg = state_reg.w_data[CFG_NOTICE_LSB +: NOTICE_W]; // R06
                    end
                end
                default: state_next.bresp = state_next.bresp;
            endcase
        end
        if (state_reg.bvalid && i_bready)
        begin
            state_next.bvalid = 1'b0;
        end

        // Hardware sets win over a same-cycle clear
        state_next.alert = state_next.alert | alert_set; // R01 R04 R05 R07
        fault_new = (state_next.fault & ~FAULT_RO_MASK) | (i_fault_set & FAULT_W0C_MASK)
                  | (i_fault_ro & FAULT_RO_MASK); // R10 R11
        fault_new[0] = state_next.fault[0] | i_fault_ext0; // R10
        state_next.fault = fault_new;

        // Rising edges of status bits become interrupt events
        events = (state_next.alert & ~state_reg.alert_q) | (state_next.fault & ~state_reg.fault_q);
        state_next.alert_q = state_next.alert;
        state_next.fault_q = state_next.fault;
        state_next.irq_status = state_next.irq_status | events;

        if (do_read)
        begin
            state_next.rvalid = 1'b1;
            state_next.rresp = mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (i_araddr)
                OFF_ALERT_STATUS: state_next.rdata = {16'h0000, state_reg.alert}; // alert bits read as stored; R09 gating is not applied
                OFF_FAULT_SUMMARY: state_next.rdata = {16'h0000, state_reg.fault}; // R11
                OFF_IRQ_STATUS: state_next.rdata = {16'h0000, state_reg.irq_status};
                OFF_IRQ_ENABLE: state_next.rdata = {16'h0000, state_reg.irq_enable};
                OFF_CONFIG:
                begin
                    state_next.rdata = 32'h0000_0000;
                    state_next.rdata[CFG_THERMAL_EN_BIT] = state_reg.thermal_enable;
                    state_next.rdata[CFG_NOTICE_LSB +: NOTICE_W] = state_reg.notice_cfg;
                end
                OFF_ENGINE: state_next.rdata = {28'h000_0000, i_thermal_halt, i_calib_halt,
                                                i_progress_tick, i_balance_done};
                default: state_next.rdata = 32'h0000_0000;
            endcase
        end
        else if (state_reg.rvalid && i_rready)
        begin
            state_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg <= '0; // R11
            state_reg.fault <= FAULT_RESET; // R11
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign o_awready = !state_reg.aw_held;
    assign o_wready = !state_reg.w_held;
    assign o_bvalid = state_reg.bvalid;
    assign o_bresp = state_reg.bresp;
    assign o_arready = !state_reg.rvalid;
    assign o_rvalid = state_reg.rvalid;
    assign o_rdata = state_reg.rdata;
    assign o_rresp = state_reg.rresp;
    assign o_thermal_enable = state_reg.thermal_enable;
    assign o_progress_notice_config = state_reg.notice_cfg;
    assign o_irq = |(state_reg.irq_status & state_reg.irq_enable);
endmodule : bafs_regs

//--- rtl/bafs_pkg.sv
package bafs_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_ALERT_STATUS = 8'h10;
    // Printed offset is a word index, not a byte address
    localparam int IDX_FAULT_SUMMARY = 5;
    localparam logic [ADDR_W-1:0] OFF_FAULT_SUMMARY = 8'(IDX_FAULT_SUMMARY * 4);
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_CONFIG = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_ENGINE = 8'h28;
    localparam int BIT_THERMAL = 14;
    localparam int BIT_CALIB = 13;
    localparam int BIT_PROGRESS = 12;
    localparam int BIT_COMPLETE = 11;
    localparam logic [15:0] FAULT_RO_MASK = 16'h3c00;
    localparam logic [15:0] FAULT_W0C_MASK = 16'hc3fe;
    localparam logic [15:0] FAULT_RESET = 16'h0000;
    localparam logic [15:0] ALERT_MASK = 16'h7800;
    localparam int CFG_THERMAL_EN_BIT = 0;
    localparam int CFG_NOTICE_LSB = 4;
    localparam int NOTICE_W = 2;
    localparam logic [NOTICE_W-1:0] NOTICE_OFF = 2'h0;
    localparam logic [NOTICE_W-1:0] NOTICE_EACH = 2'h1;
    localparam logic [NOTICE_W-1:0] NOTICE_HALF = 2'h2;
    localparam logic [NOTICE_W-1:0] NOTICE_QUARTER = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [15:0] ZERO16 = 16'h0000;
endpackage : bafs_pkg

//--- testbench/bafs_regs_chk.sv
module bafs_regs_chk
    import bafs_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic [bafs_pkg::ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] o_rresp,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [15:0] i_fault_ro
);
    logic [ADDR_W-1:0] ra_reg;
    wire logic ar_hs = i_arvalid && o_arready;
    // Remember the read address so the answer can be judged by target
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
        if (!i_rst_n)
            ra_reg <= '0;
        else if (ar_hs)
            ra_reg <= i_araddr;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    AST_RD_TIME: assert property (ar_hs |=> o_rvalid)
        else $error("read answer late");
    AST_RD_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped");
    AST_WR_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid)
        else $error("write answer dropped");
    AST_WR_TIME: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:3] o_bvalid)
        else $error("write answer late");
    AST_UPPER_ZERO: assert property (o_rvalid |-> o_rdata[31:16] == 16'h0000)
        else $error("upper half not zero");
    AST_ALERT_ONLY: assert property (o_rvalid && ra_reg == OFF_ALERT_STATUS
        |-> (o_rdata[15:0] & ~ALERT_MASK) == ZERO16)
        else $error("stray alert bit");
    AST_FAULT_RO: assert property (o_rvalid && ra_reg == OFF_FAULT_SUMMARY
        |-> o_rdata[13:10] == i_fault_ro[13:10])
        else $error("read-only fault bits wrong");
    AST_SLVERR_ZERO: assert property (o_rvalid && o_rresp == RESP_SLVERR |-> o_rdata == '0)
        else $error("refused read not zero");
    cover property (o_rvalid && o_rresp == RESP_SLVERR);
    cover property (o_rvalid && ra_reg == OFF_ALERT_STATUS && o_rdata[15:0] == ALERT_MASK);
    cover property (o_rvalid && ra_reg == OFF_FAULT_SUMMARY && o_rdata[13:10] != 4'h0);
endmodule : bafs_regs_chk

//--- testbench/bafs_regs_test.sv
module bafs_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    import bafs_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic ext0 = 1'b0, awready, wready, bvalid, arready, rvalid, th_en, irq, ta, tw, tb;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, d;
    logic [3:0] ev = '0;
    logic [15:0] f_set = '0, f_ro = '0;
    logic [1:0] bresp, rresp, ncfg, r;
    int n_errors = 0, check_count = 0, k;
    always #25 clk = ~clk;
    bafs_regs i_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
        .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
        .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_thermal_halt(ev[3]), .i_calib_halt(ev[2]),
        .i_progress_tick(ev[1]), .i_balance_done(ev[0]), .i_fault_set(f_set), .i_fault_ro(f_ro),
        .i_fault_ext0(ext0), .o_thermal_enable(th_en), .o_progress_notice_config(ncfg), .o_irq(irq));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // Sampling at the falling edge sees what the next rising edge will take
    task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= {16'h0000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) break;
        end
        bready <= 1'b0;
        if (k == 20) n_errors++;
        if (k == 20) end_sim();
        chk("bresp", er, r);
    endtask : wr
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(negedge clk);
            ta = arvalid && arready;
            tb = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (tb) break;
        end
        rready <= 1'b0;
        if (k == 20) n_errors++;
        if (k == 20) end_sim();
        chk(nm, e, d);
        chk("rresp", er, r);
    endtask : rc
    task automatic pulse(input logic [3:0] e);
        @(posedge clk);
        ev <= e;
        @(posedge clk);
        ev <= 4'h0;
    endtask : pulse
    task automatic t_alerts;
        rc("fault", OFF_FAULT_SUMMARY, '0, RESP_OKAY);
        wr(OFF_CONFIG, 16'h0000, RESP_OKAY);
        pulse(4'h8);
        rc("th_off", OFF_ALERT_STATUS, '0, RESP_OKAY);
        wr(OFF_CONFIG, 16'h0011, RESP_OKAY);
        chk("cfg", {th_en, ncfg}, {1'b1, NOTICE_EACH});
        pulse(4'hf);
        rc("all", OFF_ALERT_STATUS, ALERT_MASK, RESP_OKAY);
        wr(OFF_ALERT_STATUS, 16'hffff, RESP_OKAY);
        rc("w1", OFF_ALERT_STATUS, ALERT_MASK, RESP_OKAY);
        wr(OFF_ALERT_STATUS, 16'h0000, RESP_OKAY);
        rc("w0", OFF_ALERT_STATUS, '0, RESP_OKAY);
        wr(OFF_CONFIG, 16'h0001, RESP_OKAY);
        pulse(4'h2);
        rc("tick", OFF_ALERT_STATUS, '0, RESP_OKAY);
    endtask : t_alerts
    task automatic t_fault;
        @(posedge clk);
        f_ro <= FAULT_RO_MASK;
        f_set <= FAULT_W0C_MASK;
        ext0 <= 1'b1;
        @(posedge clk);
        f_set <= '0;
        ext0 <= 1'b0;
        rc("f_all", OFF_FAULT_SUMMARY, 32'h0000_ffff, RESP_OKAY);
        wr(OFF_FAULT_SUMMARY, 16'h0001, RESP_OKAY);
        rc("f_w0", OFF_FAULT_SUMMARY, 32'h0000_3c01, RESP_OKAY);
        rc("bad", 8'h40, '0, RESP_SLVERR);
        wr(8'h40, 16'hffff, RESP_SLVERR);
    endtask : t_fault
    task automatic t_irq;
        wr(OFF_IRQ_CLEAR, 16'hffff, RESP_OKAY);
        wr(OFF_IRQ_ENABLE, 16'h4000, RESP_OKAY);
        wr(OFF_CONFIG, 16'h0001, RESP_OKAY);
        pulse(4'h8);
        @(negedge clk);
        chk("irq_on", 1'b1, irq);
        wr(OFF_IRQ_ENABLE, 16'h0000, RESP_OKAY);
        @(negedge clk);
        chk("irq_mask", 1'b0, irq);
        wr(OFF_IRQ_ENABLE, 16'h4000, RESP_OKAY);
        wr(OFF_IRQ_CLEAR, 16'h4000, RESP_OKAY);
        @(negedge clk);
        chk("irq_clr", 1'b0, irq);
    endtask : t_irq
    task automatic t_pace;
        wr(OFF_ALERT_STATUS, 16'h0000, RESP_OKAY);
        rc("ist0", OFF_IRQ_STATUS, '0, RESP_OKAY);
        wr(OFF_CONFIG, 16'h0021, RESP_OKAY);
        pulse(4'h2);
        rc("half1", OFF_ALERT_STATUS, '0, RESP_OKAY);
        pulse(4'h2);
        rc("half2", OFF_ALERT_STATUS, 32'h0000_1000, RESP_OKAY);
        rc("ist1", OFF_IRQ_STATUS, 32'h0000_1000, RESP_OKAY);
        rc("ien", OFF_IRQ_ENABLE, 32'h0000_4000, RESP_OKAY);
    endtask : t_pace
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_alerts();
        t_fault();
        t_irq();
        t_pace();
        end_sim();
    end
endmodule : bafs_regs_test
bind bafs_regs bafs_regs_chk i_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .i_fault_ro(i_fault_ro));
